// ===== chip_select_pkg.sv
// constants, register map and field layout of the chip-select option logic
`default_nettype none
package chip_select_pkg;
  localparam int NUM_SELECTS = 12;
  localparam int REG_W = 16;
  localparam int IDX_W = 12;
  // register index map (word addresses on the bus)
  localparam logic [IDX_W-1:0] IDX_LATCH = 12'ha41;
  localparam logic [IDX_W-1:0] IDX_PIN_ASSIGN0 = 12'ha44;
  localparam logic [IDX_W-1:0] IDX_PIN_ASSIGN1 = 12'ha46;
  localparam logic [IDX_W-1:0] IDX_BASE_FIRST = 12'ha48;
  localparam logic [IDX_W-1:0] IDX_OPT_FIRST = 12'ha4a;
  localparam logic [IDX_W-1:0] IDX_STRIDE = 12'h004;
  // option register fields
  localparam int OPT_MODE = 15;
  localparam int OPT_BYTE_LSB = 13;
  localparam int OPT_RW_LSB = 11;
  localparam int OPT_STROBE_SELECT = 10;
  localparam int OPT_TERM_LSB = 6;
  localparam int OPT_SPACE_LSB = 4;
  localparam int OPT_LEVEL_LSB = 1;
  localparam int OPT_AUTOVECTOR_ACK = 0;
  // base register fields
  localparam int BASE_ADDR_LSB = 3;
  localparam int BASE_ADDR_W = 13;
  localparam int ADDR_CMP_LSB = 11;
  // reset values
  localparam logic [REG_W-1:0] BOOT_OPT_RESET = 16'h7b70;
  localparam logic [REG_W-1:0] BOOT_BASE_RESET = 16'h0007;
  localparam logic [REG_W-1:0] OPT_RESET = 16'h0000;
  localparam logic [REG_W-1:0] BASE_RESET = 16'h0000;
  localparam logic [REG_W-1:0] PIN_ASSIGN0_RESET = 16'h3fff;
  localparam logic [REG_W-1:0] PIN_ASSIGN1_RESET = 16'h03ff;
  localparam logic [REG_W-1:0] PIN_ASSIGN0_MASK = 16'h3fff;
  localparam logic [REG_W-1:0] PIN_ASSIGN1_MASK = 16'h03ff;
  localparam logic [6:0] LATCH_RESET = 7'h00;
  // pin assignment encodings
  localparam logic [1:0] PIN_DISCRETE = 2'h0;
  localparam logic [1:0] PIN_DEFAULT = 2'h1;
  localparam logic [1:0] PIN_SEL8 = 2'h2;
  localparam logic [1:0] PIN_SEL16 = 2'h3;
  // byte, direction and space encodings
  localparam logic [1:0] BYTE_LOWER = 2'h1;
  localparam logic [1:0] BYTE_UPPER = 2'h2;
  localparam logic [1:0] BYTE_BOTH = 2'h3;
  localparam logic [1:0] RW_READ = 2'h1;
  localparam logic [1:0] RW_WRITE = 2'h2;
  localparam logic [1:0] RW_BOTH = 2'h3;
  localparam logic [1:0] SPACE_CPU = 2'h0;
  localparam logic [1:0] SPACE_USER = 2'h1;
  localparam logic [1:0] SPACE_SUPER = 2'h2;
  localparam logic [1:0] SPACE_BOTH = 2'h3;
  localparam logic [2:0] FC_CPU = 3'h7;
  localparam logic [3:0] INTERRUPT_ACKNOWLEDGE_TYPE = 4'hf;
  localparam logic [2:0] LEVEL_ANY = 3'h0;
  // termination encodings and counts
  localparam logic [3:0] TERM_FAST = 4'he;
  localparam logic [3:0] TERM_EXT = 4'hf;
  localparam logic [3:0] CNT_MAX = 4'hf;
  // discrete output pins: select 4..10 carry latch bits 0..6
  localparam int DISC_FIRST = 4;
  localparam int DISC_W = 7;
  localparam int SLOW_PERIPHERAL_CLOCK_SEL = 11;
  typedef enum logic [1:0] {BUS_IDLE = 2'b00, BUS_ACK = 2'b01} bus_state_e;
endpackage
`default_nettype wire

// ===== select_qualify.sv
// per chip-select qualification of the current bus cycle
`default_nettype none
module select_qualify
  import chip_select_pkg::*;
(
  // configuration
  input wire logic [REG_W-1:0] base_in,
  input wire logic [REG_W-1:0] opt_in,
  input wire logic [1:0] pin_field_in,
  // bus cycle
  input wire logic [23:0] bus_addr_in,
  input wire logic bus_read_in,
  input wire logic [2:0] func_code_in,
  input wire logic upper_byte_in,
  input wire logic lower_byte_in,
  // result
  output logic match_out
);
  logic [2:0] blk;
  logic [BASE_ADDR_W-1:0] mask;
  logic addr_ok, byte_ok, rw_ok, space_ok, cpu_cycle, interrupt_acknowledge_cycle;
  logic [2:0] level;
  always_comb begin
    blk = base_in[2:0];
    // compared lines shrink with block size, always from the top
    case (blk)
      3'h0: mask = 13'h1fff;
      3'h1: mask = 13'h1ffc;
      3'h2: mask = 13'h1ff8;
      3'h3: mask = 13'h1fe0;
      3'h4: mask = 13'h1fc0;
      3'h5: mask = 13'h1f80;
      3'h6: mask = 13'h1f00;
      default: mask = 13'h1e00;
    endcase
    addr_ok = ((bus_addr_in[23:ADDR_CMP_LSB] ^ base_in[REG_W-1:BASE_ADDR_LSB]) & mask) == '0;
    // byte field only for a 16-bit port
    byte_ok = 1'b1;
    if (pin_field_in == PIN_SEL16) begin
      case (opt_in[OPT_BYTE_LSB+:2])
        BYTE_LOWER: byte_ok = lower_byte_in;
        BYTE_UPPER: byte_ok = upper_byte_in;
        BYTE_BOTH: byte_ok = lower_byte_in | upper_byte_in;
        default: byte_ok = 1'b0;
      endcase
    end
    // direction qualifier; reserved code never asserts
    case (opt_in[OPT_RW_LSB+:2])
      RW_READ: rw_ok = bus_read_in;
      RW_WRITE: rw_ok = !bus_read_in;
      RW_BOTH: rw_ok = 1'b1;
      default: rw_ok = 1'b0;
    endcase
    cpu_cycle = func_code_in == FC_CPU;
    interrupt_acknowledge_cycle = cpu_cycle && (bus_addr_in[19:16] == INTERRUPT_ACKNOWLEDGE_TYPE);
    level = opt_in[OPT_LEVEL_LSB+:3];
    case (opt_in[OPT_SPACE_LSB+:2])
      // acknowledge level compare; level gates select, acknowledge and autovector alike
      SPACE_CPU: space_ok = interrupt_acknowledge_cycle && (level == LEVEL_ANY || level == bus_addr_in[3:1]);
      SPACE_USER: space_ok = !cpu_cycle && !func_code_in[2];
      SPACE_SUPER: space_ok = !cpu_cycle && func_code_in[2];
      SPACE_BOTH: space_ok = !cpu_cycle;
      default: space_ok = 1'b0;
    endcase
    match_out = addr_ok && byte_ok && rw_ok && space_ok;
  end
endmodule
`default_nettype wire

// ===== chip_select_option_logic.sv
// chip-select option logic: registers, select timing, termination and discrete pins
//
// Summary of operation
// - A select asserts only when all base and option conditions match the cycle.
// - Internal acknowledge or autovector needs the same full match.
// - Mode 0 follows bus strobes; mode 1 waits for the slow peripheral clock.
// - Async strobe bit 1 times on data strobe, 0 on address strobe.
// - 16-bit port byte field: none, lower, upper or either byte.
// - Direction field: read only, write only, both; code 00 reserved.
// - Async termination codes 0..13 acknowledge after that many wait states.
// - Termination code 1110 gives fast two-cycle termination.
// - Code 1111 gives no internal acknowledge; the peripheral must end the cycle.
// - Sync mode ignores termination and flags a pending slow-clock cycle.
// - Space field: processor, user, supervisor, or supervisor and user.
// - Processor space compares acknowledge level on address lines 3..1.
// - Level 000 matches any acknowledge level, others only that level.
// - Level field gates select response and autovector termination alike.
// - Async processor space with autovector bit set gives internal autovector termination.
// - Boot option register resets to 0x7b70.
// - Latch bits 6..0 drive selects 10..4 when assigned as discrete outputs.
// - Latch bit 7 reads zero and ignores writes; others read and write.
// - 8-bit port selects ignore the byte lines; 16-bit use byte field.
// - Address compare uses only the upper lines chosen by block size.
`default_nettype none
module chip_select_option_logic
  import chip_select_pkg::*;
#(
  parameter int NSEL = NUM_SELECTS
) (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  // avalon-mm slave
  input wire logic [IDX_W-1:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [REG_W-1:0] writedata_in,
  input wire logic [1:0] byteenable_in,
  output logic [REG_W-1:0] readdata_out,
  output logic waitrequest_out,
  // internal bus cycle
  input wire logic [23:0] bus_addr_in,
  input wire logic bus_read_in,
  input wire logic [2:0] func_code_in,
  input wire logic address_strobe_in,
  input wire logic data_strobe_in,
  input wire logic upper_byte_in,
  input wire logic lower_byte_in,
  input wire logic slow_peripheral_clock_in,
  // terminations to the external bus interface
  output logic transfer_acknowledge_out,
  output logic autovector_ack_out,
  output logic slow_peripheral_clock_pending_out,
  // pins
  output logic [NSEL-1:0] select_n_out,
  output logic [NSEL-1:0] pin_level_out
);
  typedef struct packed {
    bus_state_e bstate;
    logic [REG_W-1:0] readdata;
    logic [REG_W-1:0] pin_assign0;
    logic [REG_W-1:0] pin_assign1;
    logic [NSEL-1:0][REG_W-1:0] base;
    logic [NSEL-1:0][REG_W-1:0] opt;
    logic [DISC_W-1:0] latch;
    logic [NSEL-1:0] cs_act;
    logic [NSEL-1:0] pin;
    logic [3:0] cnt;
    logic ack;
    logic autovector_ack;
    logic pending;
    logic slow_peripheral_clock_prev;
  } state_s;

  state_s st_q, st_d;
  logic [NSEL-1:0] full_match, async_sel, sync_sel, term_int, autovector_ack_sel;
  logic [2*NSEL-1:0] pa_all;
  logic [NSEL-1:0][3:0] thr;
  logic [3:0] min_thr;
  logic e_rise;

  assign pa_all = {st_q.pin_assign1[9:0], st_q.pin_assign0[13:0]};
  assign e_rise = slow_peripheral_clock_in && !st_q.slow_peripheral_clock_prev;

  ////////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < NSEL; g++) begin : gen_sel
      select_qualify u_qual (
        .base_in(st_q.base[g]),
        .opt_in(st_q.opt[g]),
        .pin_field_in(pa_all[2*g+:2]),
        .bus_addr_in(bus_addr_in),
        .bus_read_in(bus_read_in),
        .func_code_in(func_code_in),
        .upper_byte_in(upper_byte_in),
        .lower_byte_in(lower_byte_in),
        .match_out(full_match[g])
      );
      assign async_sel[g] = !st_q.opt[g][OPT_MODE];
      assign sync_sel[g] = st_q.opt[g][OPT_MODE];
      assign term_int[g] = async_sel[g] && st_q.opt[g][OPT_TERM_LSB+:4] != TERM_EXT;
      // fast termination acknowledges on the first counted cycle
      assign thr[g] = (st_q.opt[g][OPT_TERM_LSB+:4] == TERM_FAST) ? 4'h0 : st_q.opt[g][OPT_TERM_LSB+:4] + 4'h1;
      assign autovector_ack_sel[g] = async_sel[g] && st_q.opt[g][OPT_SPACE_LSB+:2] == SPACE_CPU && st_q.opt[g][OPT_AUTOVECTOR_ACK];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    // the earliest internal termination among matching selects wins
    min_thr = CNT_MAX;
    for (int i = 0; i < NSEL; i++) begin
      if (full_match[i] && term_int[i] && thr[i] < min_thr) begin
        min_thr = thr[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic hit;
    logic [IDX_W-1:0] bidx;
    logic [IDX_W-1:0] oidx;
    logic [REG_W-1:0] wmask;
    hit = 1'b0;
    bidx = '0;
    oidx = '0;
    st_d = st_q;
    wmask = {{8{byteenable_in[1]}}, {8{byteenable_in[0]}}};
    // register bus: answer one cycle after the request, write at the answer edge
    case (st_q.bstate)
      BUS_IDLE: begin
        if (read_in || write_in) begin
          st_d.bstate = BUS_ACK;
          st_d.readdata = '0;
          if (address_in == IDX_LATCH) begin
            st_d.readdata = {9'h000, st_q.latch};
          end
          if (address_in == IDX_PIN_ASSIGN0) begin
            st_d.readdata = st_q.pin_assign0;
          end
          if (address_in == IDX_PIN_ASSIGN1) begin
            st_d.readdata = st_q.pin_assign1;
          end
          for (int i = 0; i < NSEL; i++) begin
            bidx = IDX_BASE_FIRST + IDX_W'(i) * IDX_STRIDE;
            oidx = IDX_OPT_FIRST + IDX_W'(i) * IDX_STRIDE;
            if (address_in == bidx) begin
              st_d.readdata = st_q.base[i];
            end
            if (address_in == oidx) begin
              st_d.readdata = st_q.opt[i];
            end
          end
        end
      end
      BUS_ACK: begin
        st_d.bstate = BUS_IDLE;
        if (write_in) begin
          if (address_in == IDX_LATCH && byteenable_in[0]) begin
            st_d.latch = writedata_in[DISC_W-1:0];
          end
          if (address_in == IDX_PIN_ASSIGN0) begin
            st_d.pin_assign0 = ((writedata_in & wmask) | (st_q.pin_assign0 & ~wmask)) & PIN_ASSIGN0_MASK;
          end
          if (address_in == IDX_PIN_ASSIGN1) begin
            st_d.pin_assign1 = ((writedata_in & wmask) | (st_q.pin_assign1 & ~wmask)) & PIN_ASSIGN1_MASK;
          end
          for (int i = 0; i < NSEL; i++) begin
            bidx = IDX_BASE_FIRST + IDX_W'(i) * IDX_STRIDE;
            oidx = IDX_OPT_FIRST + IDX_W'(i) * IDX_STRIDE;
            if (address_in == bidx) begin
              st_d.base[i] = (writedata_in & wmask) | (st_q.base[i] & ~wmask);
            end
            if (address_in == oidx) begin
              st_d.opt[i] = (writedata_in & wmask) | (st_q.opt[i] & ~wmask);
            end
          end
        end
      end
      default: begin
        st_d.bstate = BUS_IDLE;
      end
    endcase

    // bus cycle timing
    st_d.slow_peripheral_clock_prev = slow_peripheral_clock_in;
    if (!address_strobe_in) begin
      st_d.cs_act = '0;
      st_d.cnt = '0;
      st_d.ack = 1'b0;
      st_d.autovector_ack = 1'b0;
      st_d.pending = 1'b0;
    end else begin
      if (st_q.cnt != CNT_MAX) begin
        st_d.cnt = st_q.cnt + 4'h1;
      end
      for (int i = 0; i < NSEL; i++) begin
        if (async_sel[i]) begin
          // async select follows the chosen strobe
          st_d.cs_act[i] = full_match[i] && (st_q.opt[i][OPT_STROBE_SELECT] ? data_strobe_in : address_strobe_in);
        end else begin
          // sync select asserts from a slow clock rise onward
          st_d.cs_act[i] = st_q.cs_act[i] || (full_match[i] && e_rise);
        end
      end
      // internal acknowledge only for async internal codes
      st_d.ack = st_q.ack || ((|(full_match & term_int)) && st_q.cnt >= min_thr);
      st_d.autovector_ack = |(full_match & autovector_ack_sel);
      // sync match flags a pending slow-clock cycle
      st_d.pending = |(full_match & sync_sel & ~st_d.cs_act);
    end

    // pin drive
    for (int i = 0; i < NSEL; i++) begin
      hit = pa_all[2*i+1];
      st_d.pin[i] = hit ? !st_d.cs_act[i] : 1'b1;
      if (pa_all[2*i+:2] == PIN_DISCRETE && i >= DISC_FIRST && i < DISC_FIRST + DISC_W) begin
        st_d.pin[i] = st_d.latch[i-DISC_FIRST];
      end
      if (pa_all[2*i+:2] == PIN_DISCRETE && i == SLOW_PERIPHERAL_CLOCK_SEL) begin
        st_d.pin[i] = slow_peripheral_clock_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_q <= '0;
      st_q.bstate <= BUS_IDLE;
      st_q.pin_assign0 <= PIN_ASSIGN0_RESET;
      st_q.pin_assign1 <= PIN_ASSIGN1_RESET;
      st_q.latch <= LATCH_RESET;
      st_q.pin <= '1;
      for (int i = 0; i < NSEL; i++) begin
        st_q.base[i] <= BASE_RESET;
        st_q.opt[i] <= OPT_RESET;
      end
      st_q.base[0] <= BOOT_BASE_RESET;
      st_q.opt[0] <= BOOT_OPT_RESET;
    end else if (clk_en_in) begin
      st_q <= st_d;
    end
  end

  assign readdata_out = st_q.readdata;
  assign waitrequest_out = st_q.bstate != BUS_ACK;
  assign transfer_acknowledge_out = st_q.ack;
  assign autovector_ack_out = st_q.autovector_ack;
  assign slow_peripheral_clock_pending_out = st_q.pending;
  assign select_n_out = ~st_q.cs_act;
  assign pin_level_out = st_q.pin;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in || !clk_en_in);

  AST_SELECT_CAUSE: assert property ((st_q.cs_act & ~$past(full_match) & $past(async_sel)) == '0)
    else $error("async select asserted without full match");
  AST_ACK_CAUSE: assert property ($rose(st_q.ack) |-> $past(|(full_match & term_int)))
    else $error("acknowledge without internal-terminating match");
  AST_DS_TIMING: assert property (st_q.cs_act[0] && $past(async_sel[0] && st_q.opt[0][OPT_STROBE_SELECT])
    |-> $past(data_strobe_in))
    else $error("data strobe select asserted without data strobe");
  AST_WAIT_COUNT: assert property ($rose(st_q.ack) |-> $past(st_q.cnt) >= $past(min_thr))
    else $error("acknowledge before wait states elapsed");
  AST_EXT_NO_ACK: assert property ((|(full_match & term_int)) == 1'b0 && !st_q.ack |=> !st_q.ack)
    else $error("acknowledge with external termination only");
  AST_SYNC_PEND: assert property (st_q.pending |-> $past(|(full_match & sync_sel)))
    else $error("pending flag without sync match");
  AST_AUTOVECTOR_ACK: assert property (st_q.autovector_ack |-> $past(|(full_match & autovector_ack_sel)))
    else $error("autovector without qualifying match");
  AST_BOOT_RESET: assert property ($past(rst_in) |-> st_q.opt[0] == BOOT_OPT_RESET)
    else $error("boot option register reset value wrong");
  AST_DISCRETE: assert property ($past(pa_all[9:8] == PIN_DISCRETE) |-> st_q.pin[4] == $past(st_d.latch[0]))
    else $error("discrete pin does not follow latch");
  AST_BIT7: assert property (st_q.bstate == BUS_ACK && $past(address_in == IDX_LATCH)
    |-> st_q.readdata[REG_W-1:DISC_W] == '0)
    else $error("latch upper bits not zero");
  AST_CYCLE_END: assert property (!address_strobe_in |=> st_q.cs_act == '0 && !st_q.ack && !st_q.autovector_ack)
    else $error("select or termination held after cycle end");

  COV_BOOT_SELECT: cover property (st_q.cs_act[0] ##[1:20] st_q.ack);
  COV_FAST: cover property ($rose(st_q.ack) && $past(min_thr) == 4'h0);
  COV_AUTOVECTOR_ACK: cover property ($rose(st_q.autovector_ack));
  COV_SYNC: cover property (st_q.pending ##[1:40] st_q.cs_act != '0);
endmodule
`default_nettype wire

// ===== peripheral_model.sv
// external peripheral model that ends its own cycles with an acknowledge
`default_nettype none
module peripheral_model #(
  parameter int ACK_DELAY = 4
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // bus side
  input wire logic select_n_in,
  output logic ack_out
);
  timeunit 1ns;
  timeprecision 100ps;
  int count_q;
  ////////////////////////////////////////////////////////////////////////////
  // acknowledge while selected
  // a large delay models a slow device; ack drops at the first clock edge after select releases
  always @(posedge clk_in) begin
    if (rst_in || select_n_in) begin
      count_q <= 0;
      ack_out <= 1'b0;
    end else begin
      count_q <= count_q + 1;
      ack_out <= (count_q >= ACK_DELAY - 1);
    end
  end
endmodule
`default_nettype wire

// ===== tb_chip_select_option_logic.sv
// self-checking testbench of the chip-select option logic
`default_nettype none
module tb_chip_select_option_logic
  import chip_select_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [IDX_W-1:0] address_in = '0;
  logic read_in = 1'b0;
  logic write_in = 1'b0;
  logic [REG_W-1:0] writedata_in = '0;
  logic [1:0] byteenable_in = 2'h3;
  logic [REG_W-1:0] readdata_out;
  logic waitrequest_out;
  logic [23:0] bus_addr_in = '0;
  logic bus_read_in = 1'b1;
  logic [2:0] func_code_in = 3'h5;
  logic address_strobe_in = 1'b0;
  logic data_strobe_in = 1'b0;
  logic upper_byte_in = 1'b1;
  logic lower_byte_in = 1'b1;
  logic slow_peripheral_clock_in = 1'b0;
  logic transfer_acknowledge_out;
  logic autovector_ack_out;
  logic slow_peripheral_clock_pending_out;
  logic ext_ack;
  logic [NUM_SELECTS-1:0] select_n_out;
  logic [NUM_SELECTS-1:0] pin_level_out;
  int err_count = 0;
  int n_compared = 0;
  int cyc_n = 0;

  always #2.5 clk_in = ~clk_in;

  chip_select_option_logic dut (.clk_in(clk_in), .rst_in(rst_in), .clk_en_in(1'b1), .address_in(address_in),
    .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in), .byteenable_in(byteenable_in),
    .readdata_out(readdata_out), .waitrequest_out(waitrequest_out), .bus_addr_in(bus_addr_in),
    .bus_read_in(bus_read_in), .func_code_in(func_code_in), .address_strobe_in(address_strobe_in),
    .data_strobe_in(data_strobe_in), .upper_byte_in(upper_byte_in), .lower_byte_in(lower_byte_in),
    .slow_peripheral_clock_in(slow_peripheral_clock_in), .transfer_acknowledge_out(transfer_acknowledge_out),
    .autovector_ack_out(autovector_ack_out), .slow_peripheral_clock_pending_out(slow_peripheral_clock_pending_out),
    .select_n_out(select_n_out), .pin_level_out(pin_level_out));

  peripheral_model #(.ACK_DELAY(4)) periph (.clk_in(clk_in), .rst_in(rst_in), .select_n_in(select_n_out[0]),
    .ack_out(ext_ack));

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // the ceiling is more than fifty times the length of the whole sequence
  always @(posedge clk_in) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      err_count++;
      $display("FAIL %0t run timed out", $time);
      close_out();
    end
  end

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    chk16({15'h0, got}, {15'h0, exp}, what);
  endtask

  task automatic chkn(input int got, input int exp, input string what);
    n_compared++;
    if (got != exp) begin
      err_count++;
      $display("FAIL %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // request held until waitrequest is seen low at a rising edge
  task automatic reg_rw(input logic wr, input logic [IDX_W-1:0] a, input logic [15:0] wd, output logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    address_in <= a;
    writedata_in <= wd;
    read_in <= ~wr;
    write_in <= wr;
    do begin
      @(posedge clk_in);
      n++;
    end while (waitrequest_out !== 1'b0 && n < 50);
    d = readdata_out;
    read_in <= 1'b0;
    write_in <= 1'b0;
  endtask

  task automatic reg_wr(input logic [IDX_W-1:0] a, input logic [15:0] wd);
    logic [15:0] d;
    reg_rw(1'b1, a, wd, d);
  endtask

  function automatic logic [15:0] opt(input logic md, input logic [1:0] by, input logic [1:0] rw, input logic sb,
      input logic [3:0] tm, input logic [1:0] sp, input logic [2:0] lv, input logic av);
    return {md, by, rw, sb, tm, sp, lv, av};
  endfunction

  function automatic logic [15:0] q(input logic [1:0] by, input logic [1:0] rw, input logic [1:0] sp);
    return opt(1'b0, by, rw, 1'b0, TERM_EXT, sp, LEVEL_ANY, 1'b0);
  endfunction

  task automatic start_cycle(input logic [23:0] a, input logic rd, input logic [2:0] fc, input logic [1:0] bl,
      input logic ds);
    @(posedge clk_in);
    bus_addr_in <= a;
    bus_read_in <= rd;
    func_code_in <= fc;
    upper_byte_in <= bl[1];
    lower_byte_in <= bl[0];
    address_strobe_in <= 1'b1;
    data_strobe_in <= ds;
  endtask

  // strobes stay low for at least two cycles before the next bus cycle
  task automatic end_cycle();
    @(posedge clk_in);
    address_strobe_in <= 1'b0;
    data_strobe_in <= 1'b0;
    @(posedge clk_in);
    #1;
    chk1(select_n_out[0], 1'b1, "select release");
    chk1(transfer_acknowledge_out | autovector_ack_out, 1'b0, "ack release");
  endtask

  task automatic probe(input logic [15:0] o, input logic [23:0] a, input logic rd, input logic [2:0] fc,
      input logic [1:0] bl, input logic exp);
    reg_wr(IDX_OPT_FIRST, o);
    start_cycle(a, rd, fc, bl, 1'b1);
    repeat (2) @(posedge clk_in);
    #1;
    chk1(select_n_out[0], exp, "qualified select");
    end_cycle();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [15:0] d;
    reg_rw(1'b0, IDX_OPT_FIRST, 16'h0, d);
    chk16(d, BOOT_OPT_RESET, "boot option reset");
    reg_rw(1'b0, IDX_LATCH, 16'h0, d);
    chk16(d, 16'h0000, "latch reset");
    reg_wr(IDX_LATCH, 16'h00d5);
    reg_rw(1'b0, IDX_LATCH, 16'h0, d);
    chk16(d, 16'h0055, "latch top bit");
    reg_rw(1'b0, 12'h000, 16'h0, d);
    chk16(d, 16'h0000, "unmapped read");
    reg_wr(IDX_PIN_ASSIGN0, 16'h0000);
    reg_wr(IDX_PIN_ASSIGN1, 16'h0000);
    repeat (2) @(posedge clk_in);
    #1;
    chk16({9'h0, pin_level_out[10:4]}, 16'h0055, "discrete pins");
    reg_wr(IDX_PIN_ASSIGN0, PIN_ASSIGN0_RESET);
    reg_wr(IDX_PIN_ASSIGN1, PIN_ASSIGN1_RESET);
    $display("test regs done");
  endtask

  task automatic t_wait();
    logic [3:0] codes [4] = '{4'h0, 4'h1, 4'hd, TERM_FAST};
    int n;
    foreach (codes[i]) begin
      reg_wr(IDX_OPT_FIRST, opt(1'b0, BYTE_BOTH, RW_BOTH, 1'b0, codes[i], SPACE_BOTH, LEVEL_ANY, 1'b0));
      start_cycle(24'h001000, 1'b1, 3'h5, 2'h3, 1'b1);
      n = 0;
      do begin
        @(posedge clk_in);
        #1;
        n++;
      end while (transfer_acknowledge_out !== 1'b1 && n < 40);
      chkn(n, (codes[i] == TERM_FAST) ? 1 : int'(codes[i]) + 2, "ack cycles");
      chk16({4'h0, select_n_out}, 16'h0ffe, "only boot selected");
      end_cycle();
    end
    $display("test wait states done");
  endtask

  task automatic t_ext();
    reg_wr(IDX_OPT_FIRST, q(BYTE_BOTH, RW_BOTH, SPACE_BOTH));
    start_cycle(24'h002000, 1'b0, 3'h5, 2'h3, 1'b1);
    repeat (20) @(posedge clk_in);
    #1;
    chk1(transfer_acknowledge_out, 1'b0, "no internal ack");
    chk1(ext_ack, 1'b1, "peripheral ack");
    end_cycle();
    $display("test external ack done");
  endtask

  task automatic t_qual();
    probe(q(BYTE_BOTH, RW_READ, SPACE_BOTH), 24'h001000, 1'b0, 3'h5, 2'h3, 1'b1);
    probe(q(BYTE_BOTH, RW_WRITE, SPACE_BOTH), 24'h001000, 1'b0, 3'h5, 2'h3, 1'b0);
    probe(q(BYTE_BOTH, 2'h0, SPACE_BOTH), 24'h001000, 1'b1, 3'h5, 2'h3, 1'b1);
    probe(q(BYTE_BOTH, RW_BOTH, SPACE_USER), 24'h001000, 1'b1, 3'h5, 2'h3, 1'b1);
    probe(q(BYTE_BOTH, RW_BOTH, SPACE_USER), 24'h001000, 1'b1, 3'h1, 2'h3, 1'b0);
    probe(q(BYTE_BOTH, RW_BOTH, SPACE_SUPER), 24'h001000, 1'b1, 3'h1, 2'h3, 1'b1);
    probe(q(BYTE_BOTH, RW_BOTH, SPACE_BOTH), 24'h100000, 1'b1, 3'h5, 2'h3, 1'b1);
    probe(q(2'h0, RW_BOTH, SPACE_BOTH), 24'h001000, 1'b1, 3'h5, 2'h3, 1'b1);
    probe(q(BYTE_LOWER, RW_BOTH, SPACE_BOTH), 24'h001000, 1'b1, 3'h5, 2'h2, 1'b1);
    probe(q(BYTE_LOWER, RW_BOTH, SPACE_BOTH), 24'h001000, 1'b1, 3'h5, 2'h1, 1'b0);
    probe(q(BYTE_UPPER, RW_BOTH, SPACE_BOTH), 24'h001000, 1'b1, 3'h5, 2'h2, 1'b0);
    reg_wr(IDX_PIN_ASSIGN0, 16'h3ffe);
    probe(q(2'h0, RW_BOTH, SPACE_BOTH), 24'h001000, 1'b1, 3'h5, 2'h1, 1'b0);
    reg_wr(IDX_PIN_ASSIGN0, PIN_ASSIGN0_RESET);
    $display("test qualification done");
  endtask

  task automatic t_strobe();
    reg_wr(IDX_OPT_FIRST, opt(1'b0, BYTE_BOTH, RW_BOTH, 1'b1, TERM_EXT, SPACE_BOTH, LEVEL_ANY, 1'b0));
    start_cycle(24'h003000, 1'b1, 3'h5, 2'h3, 1'b0);
    repeat (3) @(posedge clk_in);
    #1;
    chk1(select_n_out[0], 1'b1, "waits for data strobe");
    @(posedge clk_in);
    data_strobe_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    chk1(select_n_out[0], 1'b0, "data strobe select");
    end_cycle();
    $display("test strobe done");
  endtask

  task automatic t_interrupt_acknowledge();
    logic [2:0] lv [4] = '{3'h3, 3'h3, 3'h0, 3'h3};
    logic [2:0] cl [4] = '{3'h3, 3'h5, 3'h6, 3'h3};
    logic av [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
    logic hit [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    logic sel_n [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
    for (int i = 0; i < 4; i++) begin
      reg_wr(IDX_OPT_FIRST, opt(1'b0, BYTE_BOTH, RW_BOTH, 1'b0, TERM_EXT, SPACE_CPU, lv[i], av[i]));
      start_cycle({8'h0f, 12'h000, cl[i], 1'b0}, 1'b1, FC_CPU, 2'h3, 1'b1);
      repeat (2) @(posedge clk_in);
      #1;
      chk1(autovector_ack_out, hit[i], "autovector");
      chk1(select_n_out[0], sel_n[i], "acknowledge level select");
      end_cycle();
    end
    $display("test interrupt acknowledge done");
  endtask

  task automatic t_sync();
    reg_wr(IDX_OPT_FIRST, opt(1'b1, BYTE_BOTH, RW_BOTH, 1'b0, TERM_FAST, SPACE_BOTH, LEVEL_ANY, 1'b0));
    start_cycle(24'h004000, 1'b1, 3'h5, 2'h3, 1'b1);
    repeat (4) @(posedge clk_in);
    #1;
    chk1(slow_peripheral_clock_pending_out, 1'b1, "slow cycle pending");
    chk1(transfer_acknowledge_out, 1'b0, "no ack in sync mode");
    chk1(select_n_out[0], 1'b1, "select waits for slow clock");
    @(posedge clk_in);
    slow_peripheral_clock_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    chk1(select_n_out[0], 1'b0, "slow clock select");
    end_cycle();
    slow_peripheral_clock_in <= 1'b0;
    $display("test sync mode done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    t_regs();
    t_wait();
    t_ext();
    t_qual();
    t_strobe();
    t_interrupt_acknowledge();
    t_sync();
    close_out();
  end
endmodule
`default_nettype wire
